// ===== logic/buck_ctrl_pkg.sv
// Package for the four-regulator mode and voltage-scaling control block.
// Assumes a single 50 MHz clock (mclk) and a synchronous active-high reset.
package buck_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Regulator count and indices
  // ----------------------------------------------------------------------
  localparam int NUM_BUCK = 4;
  localparam int IDX_A = 0;
  localparam int IDX_B = 1;
  localparam int IDX_C = 2;
  localparam int IDX_D = 3;

  // ----------------------------------------------------------------------
  // Power-mode codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_GROUP_LP = 2'h1;
  localparam logic [1:0] MODE_FORCED_LP = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  // ----------------------------------------------------------------------
  // Target-voltage codes: 0.6 V at code zero, 12.5 mV per step
  // ----------------------------------------------------------------------
  localparam int BASE_MV_X10 = 6000;
  localparam int STEP_MV_X10 = 125;
  localparam logic [7:0] MAX_CODE_A = 8'h40;
  localparam logic [7:0] MAX_CODE_B = 8'h4C;
  localparam logic [7:0] MAX_CODE_CD = 8'hDF;
  localparam logic [7:0] RESET_CODE = 8'h00;

  // ----------------------------------------------------------------------
  // Ramp timing: step time = 12.5 mV / rate
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int SS_FAST_NS = 500;
  localparam int SS_SLOW_NS = 1000;
  localparam int SS_FAST_CYC = SS_FAST_NS * CLK_MHZ / 1000;
  localparam int SS_SLOW_CYC = SS_SLOW_NS * CLK_MHZ / 1000;
  localparam int DVS_BASE_NS = 250;
  localparam int DVS_BASE_CYC = DVS_BASE_NS * CLK_MHZ / 1000;
  localparam int TIMER_W = 10;

  // ----------------------------------------------------------------------
  // Per-regulator ramp state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_SOFTSTART = 2'b01,
    RAMP_DVS = 2'b10
  } ramp_e;

  // Software configuration of one regulator
  typedef struct packed {
    logic [1:0] power_mode;
    logic seq_sel;
    logic [7:0] main_target_code;
    logic [7:0] alt_target_code;
    logic [1:0] slew_rate_sel;
    logic fall_slew_adjust_n;
    logic remote_sense_en;
  } buck_cfg_s;

  // Status of one regulator
  typedef struct packed {
    logic enabled;
    logic lowpower;
    logic remote_sense;
    logic pg_masked;
    logic [7:0] ref_code;
  } buck_stat_s;

endpackage : buck_ctrl_pkg

// ===== logic/buck_ramp.sv
// Reference ramp for one regulator: soft-start and slewed voltage scaling.
// Assumes mclk at 50 MHz; cfg inputs come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module buck_ramp (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [7:0] target,
  input wire logic ss_fast,
  input wire logic [1:0] slew_rate_sel,
  input wire logic fall_slew_adjust_n,
  output logic [7:0] ref_code,
  output logic busy
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    buck_ctrl_pkg::ramp_e mode;
    logic [7:0] code;
    logic [buck_ctrl_pkg::TIMER_W-1:0] timer;
    logic was_enabled;
  } ramp_state_s;

  ramp_state_s st;
  ramp_state_s next_st;
  logic [buck_ctrl_pkg::TIMER_W-1:0] step_cyc;

  // Cycles per 12.5 mV step: slower by powers of two per slew code
  function automatic logic [buck_ctrl_pkg::TIMER_W-1:0] dvs_step(input logic [1:0] sel, input logic down_slow);
    logic [buck_ctrl_pkg::TIMER_W-1:0] base;
    base = buck_ctrl_pkg::TIMER_W'(buck_ctrl_pkg::DVS_BASE_CYC) << sel;
    dvs_step = down_slow ? (base << 1) : base;
  endfunction : dvs_step

  // Step length for the present direction and phase
  always_comb begin
    if (st.mode == buck_ctrl_pkg::RAMP_SOFTSTART) begin
      step_cyc = ss_fast ? buck_ctrl_pkg::TIMER_W'(buck_ctrl_pkg::SS_FAST_CYC)
                         : buck_ctrl_pkg::TIMER_W'(buck_ctrl_pkg::SS_SLOW_CYC);
    end else begin
      step_cyc = dvs_step(slew_rate_sel, (target < st.code) && fall_slew_adjust_n);
    end
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.was_enabled = enable;
    if (!enable) begin
      // Reference holds its last value; output is not discharged here
      next_st.mode = buck_ctrl_pkg::RAMP_IDLE;
      next_st.timer = '0;
    end else if (!st.was_enabled) begin
      // Start from the held code, i.e. from the prebiased output
      next_st.mode = buck_ctrl_pkg::RAMP_SOFTSTART;
      next_st.timer = '0;
    end else if (st.code == target) begin
      next_st.mode = buck_ctrl_pkg::RAMP_IDLE;
      next_st.timer = '0;
    end else begin
      if (st.mode == buck_ctrl_pkg::RAMP_IDLE) begin
        next_st.mode = buck_ctrl_pkg::RAMP_DVS;
      end
      if (st.timer + 1'b1 >= step_cyc) begin
        next_st.timer = '0;
        next_st.code = (target > st.code) ? st.code + 8'h01 : st.code - 8'h01;
      end else begin
        next_st.timer = st.timer + 1'b1;
      end
    end
  end

  // Register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '{mode: buck_ctrl_pkg::RAMP_IDLE, code: buck_ctrl_pkg::RESET_CODE, timer: '0, was_enabled: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ref_code = st.code;
  assign busy = (st.mode != buck_ctrl_pkg::RAMP_IDLE) || (enable && !st.was_enabled);

  // Reference moves by at most one code step per cycle
  AST_ONE_STEP: assert property (@(posedge mclk) disable iff (reset)
    (st.code == $past(st.code)) || (st.code == $past(st.code) + 8'h01) || (st.code == $past(st.code) - 8'h01))
    else $error("reference jumped more than one step");

endmodule : buck_ramp
`default_nettype wire

// ===== logic/buck_mode_ctrl.sv
// Top of the step-down regulator mode and voltage-scaling control.
// Assumes pins are asynchronous; configuration ports come from mclk logic.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each regulator has its own mode field
// - Mode 0b10 forces low-power
// - Group mode follows global low-power signal
// - Global low-power from bit or pin0
// - Sequencer drives enable; mode picks power
// - Enable pin high enables buck_a
// - buck_c/d range 0.6 to 3.3875 V
// - buck_a limited to 0.6 to 1.4 V
// - buck_b limited to 0.6 to 1.55 V
// - Eight-bit main and alternate target codes
// - Soft-start rate chosen by fuse
// - Soft-start begins from existing output
// - Power-good masked during soft-start
// - New target approached by controlled ramp
// - Power-good masked during voltage scaling
// - Pin scaling only with alternate function enabled
// - Polarity select sets pin active level
// - Active pin selects alternate target
// - Slew set by rate field and fall bit
// - Remote sense enable per buck_a/buck_b
// - Low-power forces remote sense off
// - Enable bit kept; sense returns on normal
// - Five power stages interleaved on clock edges
// - Rising: a_phase1, b; falling: c, d, a_phase2
// - Power-fail rise raises maskable interrupt
module buck_mode_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire buck_ctrl_pkg::buck_cfg_s [3:0] cfg,
  input wire logic [3:0] seq_enable,
  input wire logic global_lowpower_bit,
  input wire logic gp_pin0,
  input wire logic gp_pin0_lp_en,
  input wire logic hw_enable_pin,
  input wire logic gp_pin5,
  input wire logic gp_pin6,
  input wire logic alt_function_en5,
  input wire logic alt_function_en6,
  input wire logic [1:0] pin_polarity_sel,
  input wire logic softstart_rate_fuse,
  input wire logic [3:0] power_fail_n,
  input wire logic power_good_irq_mask,
  input wire logic power_good_irq_clear,
  input wire logic switch_clk,
  output buck_ctrl_pkg::buck_stat_s [3:0] stat,
  output logic power_good_irq,
  output logic [3:0] power_good_flag,
  output logic [4:0] stage_start
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [3:0] fail_meta;
    logic [3:0] fail_sync;
    logic [3:0] fail_prev;
    logic [3:0] flag;
    logic [3:0] enabled;
    logic [3:0] lowpower;
    logic [3:0] remote;
    logic irq;
    logic clk_prev;
    logic [4:0] start;
  } top_state_s;

  top_state_s st;
  top_state_s next_st;

  // Synchronised pins: 0 lp pin, 1 enable pin, 2 pin5, 3 pin6, 4 switch clock
  logic gp0_s;
  logic hw_en_s;
  logic pin5_s;
  logic pin6_s;
  logic sw_clk_s;
  logic global_lp;
  logic [1:0] alt_active;
  logic [3:0] want_enable;
  logic [3:0] want_lowpower;
  logic [7:0] sel_target [4];
  logic [7:0] clamp_target [4];
  logic [7:0] ref_code [4];
  logic [3:0] ramp_busy;

  assign gp0_s = st.pin_sync[0];
  assign hw_en_s = st.pin_sync[1];
  assign pin5_s = st.pin_sync[2];
  assign pin6_s = st.pin_sync[3];
  assign sw_clk_s = st.pin_sync[4];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Clamp a target code to the regulator's ceiling
  function automatic logic [7:0] clamp_code(input logic [7:0] code, input logic [7:0] max_code);
    clamp_code = (code > max_code) ? max_code : code;
  endfunction : clamp_code

  // Per-regulator ceiling
  function automatic logic [7:0] max_of(input int idx);
    if (idx == buck_ctrl_pkg::IDX_A) begin
      max_of = buck_ctrl_pkg::MAX_CODE_A;
    end else if (idx == buck_ctrl_pkg::IDX_B) begin
      max_of = buck_ctrl_pkg::MAX_CODE_B;
    end else begin
      max_of = buck_ctrl_pkg::MAX_CODE_CD;
    end
  endfunction : max_of

  // ----------------------------------------------------------------------
  // Mode and target decode
  // ----------------------------------------------------------------------
  // Global low-power signal and pin-controlled scaling
  always_comb begin
    global_lp = global_lowpower_bit || (gp_pin0_lp_en && gp0_s);
    alt_active[0] = alt_function_en5 && (pin5_s ^ pin_polarity_sel[0]);
    alt_active[1] = alt_function_en6 && (pin6_s ^ pin_polarity_sel[1]);
  end

  // Per-regulator enable, power level and target
  always_comb begin
    for (int i = 0; i < buck_ctrl_pkg::NUM_BUCK; i++) begin
      // Mode field decoded independently per regulator
      if (cfg[i].seq_sel) begin
        want_enable[i] = seq_enable[i];
      end else begin
        want_enable[i] = (cfg[i].power_mode != buck_ctrl_pkg::MODE_OFF);
      end
      if (i == buck_ctrl_pkg::IDX_A && hw_en_s) begin
        want_enable[i] = 1'b1;
      end
      unique case (cfg[i].power_mode)
        buck_ctrl_pkg::MODE_FORCED_LP: want_lowpower[i] = 1'b1;
        buck_ctrl_pkg::MODE_GROUP_LP: want_lowpower[i] = global_lp;
        buck_ctrl_pkg::MODE_OFF: want_lowpower[i] = 1'b0;
        buck_ctrl_pkg::MODE_NORMAL: want_lowpower[i] = 1'b0;
      endcase
      // Pin scaling applies only to buck_a and buck_b
      if (i < 2 && alt_active[i[0]]) begin
        sel_target[i] = cfg[i].alt_target_code;
      end else begin
        sel_target[i] = cfg[i].main_target_code;
      end
      clamp_target[i] = clamp_code(sel_target[i], max_of(i));
    end
  end

  // ----------------------------------------------------------------------
  // Ramp instances
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < buck_ctrl_pkg::NUM_BUCK; g++) begin : g_ramp
    buck_ramp u_ramp (
      .mclk(mclk),
      .reset(reset),
      .enable(st.enabled[g]),
      .target(clamp_target[g]),
      .ss_fast(softstart_rate_fuse),
      .slew_rate_sel(cfg[g].slew_rate_sel),
      .fall_slew_adjust_n(cfg[g].fall_slew_adjust_n),
      .ref_code(ref_code[g]),
      .busy(ramp_busy[g])
    );
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Two-flop synchronisers on every pin input
    next_st.pin_meta = {switch_clk, gp_pin6, gp_pin5, hw_enable_pin, gp_pin0};
    next_st.pin_sync = st.pin_meta;
    next_st.fail_meta = power_fail_n;
    next_st.fail_sync = st.fail_meta;
    next_st.fail_prev = st.fail_sync;
    next_st.enabled = want_enable;
    next_st.lowpower = want_lowpower;
    for (int i = 0; i < buck_ctrl_pkg::NUM_BUCK; i++) begin
      // Remote sense off in low power; enable bit itself untouched
      next_st.remote[i] = (i < 2) && cfg[i].remote_sense_en && !want_lowpower[i];
      // Rising power-fail while not masked by a ramp sets sticky flag
      if (st.fail_sync[i] && !st.fail_prev[i] && !ramp_busy[i] && st.enabled[i]) begin
        next_st.flag[i] = 1'b1;
      end else if (power_good_irq_clear) begin
        next_st.flag[i] = 1'b0;
      end
    end
    next_st.irq = |next_st.flag && !power_good_irq_mask;
    // Stage starts on switching clock edges
    next_st.clk_prev = sw_clk_s;
    next_st.start[0] = sw_clk_s && !st.clk_prev && st.enabled[buck_ctrl_pkg::IDX_A];
    next_st.start[1] = sw_clk_s && !st.clk_prev && st.enabled[buck_ctrl_pkg::IDX_B];
    next_st.start[2] = !sw_clk_s && st.clk_prev && st.enabled[buck_ctrl_pkg::IDX_C];
    next_st.start[3] = !sw_clk_s && st.clk_prev && st.enabled[buck_ctrl_pkg::IDX_D];
    next_st.start[4] = !sw_clk_s && st.clk_prev && st.enabled[buck_ctrl_pkg::IDX_A];
  end

  // Register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < buck_ctrl_pkg::NUM_BUCK; i++) begin
      stat[i].enabled = st.enabled[i];
      stat[i].lowpower = st.lowpower[i];
      stat[i].remote_sense = st.remote[i];
      stat[i].pg_masked = ramp_busy[i];
      stat[i].ref_code = ref_code[i];
    end
  end
  assign power_good_irq = st.irq;
  assign power_good_flag = st.flag;
  assign stage_start = st.start;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_FORCED_LP: assert property (@(posedge mclk) disable iff (reset)
    (cfg[2].power_mode == buck_ctrl_pkg::MODE_FORCED_LP) |=> st.lowpower[2])
    else $error("forced low-power not applied");

  AST_GROUP_LP: assert property (@(posedge mclk) disable iff (reset)
    (cfg[2].power_mode == buck_ctrl_pkg::MODE_GROUP_LP && !global_lp) |=> !st.lowpower[2])
    else $error("group low-power without global signal");

  AST_GLOBAL_BIT: assert property (@(posedge mclk) disable iff (reset)
    (global_lowpower_bit && cfg[2].power_mode == buck_ctrl_pkg::MODE_GROUP_LP) |=> st.lowpower[2])
    else $error("global bit did not enter low power");

  AST_SEQ_EN: assert property (@(posedge mclk) disable iff (reset)
    (cfg[3].seq_sel) |=> (st.enabled[3] == $past(seq_enable[3])))
    else $error("sequencer enable not followed");

  AST_HW_EN: assert property (@(posedge mclk) disable iff (reset)
    hw_en_s |=> st.enabled[0])
    else $error("buck_a not enabled by pin");

  AST_CLAMP_A: assert property (@(posedge mclk) disable iff (reset)
    ref_code[0] <= buck_ctrl_pkg::MAX_CODE_A)
    else $error("buck_a reference above ceiling");

  AST_CLAMP_B: assert property (@(posedge mclk) disable iff (reset)
    ref_code[1] <= buck_ctrl_pkg::MAX_CODE_B)
    else $error("buck_b reference above ceiling");

  AST_NO_ALT: assert property (@(posedge mclk) disable iff (reset)
    !alt_function_en5 |-> clamp_target[0] == clamp_code(cfg[0].main_target_code, buck_ctrl_pkg::MAX_CODE_A))
    else $error("pin scaling active while disabled");

  AST_REMOTE_LP: assert property (@(posedge mclk) disable iff (reset)
    st.lowpower[1] |-> !st.remote[1])
    else $error("remote sense on in low power");

  AST_MASK_RAMP: assert property (@(posedge mclk) disable iff (reset)
    (ramp_busy[3] && st.fail_sync[3] && !st.fail_prev[3] && !st.flag[3]) |=> !st.flag[3])
    else $error("power-good flagged during ramp");

  AST_IRQ_MASK: assert property (@(posedge mclk) disable iff (reset)
    power_good_irq_mask |=> !power_good_irq)
    else $error("masked interrupt asserted");

  AST_RISE_EDGE: assert property (@(posedge mclk) disable iff (reset)
    stage_start[1] |-> $past(sw_clk_s) && !$past(st.clk_prev))
    else $error("buck_b started off the rising edge");

endmodule : buck_mode_ctrl
`default_nettype wire

// ===== tb/far_side_model.sv
// Far-side model: master switching clock and power-fail comparator outputs.
// Assumes the bench asks for comparator faults and for the clock to run.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic [3:0] fail_req,
  output logic switch_clk,
  output logic [3:0] power_fail_n
);
  // ----------------------------------------------------------------------
  // Switching clock, ten mclk cycles per half period
  // ----------------------------------------------------------------------
  logic [3:0] half_cnt; // Cycles into the current half period
  // Stands low while stopped, so edges come only when asked for
  always @(posedge mclk) begin
    if (!run) begin
      switch_clk <= 1'b0;
      half_cnt <= 4'h0;
    end else if (half_cnt == 4'h9) begin
      switch_clk <= ~switch_clk;
      half_cnt <= 4'h0;
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end
  // Comparators: high means the output is out of regulation
  assign power_fail_n = fail_req;
endmodule : far_side_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the regulator mode and voltage-scaling control.
// Assumes the package and design top are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic mclk, reset, global_lowpower_bit, gp_pin0, gp_pin0_lp_en, hw_enable_pin;
  logic gp_pin5, gp_pin6, alt_function_en5, alt_function_en6, softstart_rate_fuse;
  logic power_good_irq_mask, power_good_irq_clear, switch_clk, run, power_good_irq;
  buck_ctrl_pkg::buck_cfg_s [3:0] cfg; // Per-regulator settings
  buck_ctrl_pkg::buck_stat_s [3:0] stat; // Per-regulator status
  logic [3:0] seq_enable, power_fail_n, fail_req, power_good_flag;
  logic [1:0] pin_polarity_sel;
  logic [4:0] stage_start, seen; // Start pulses and their accumulation
  typedef struct {int k; int i; logic [7:0] want;} note_s;
  note_s q[$]; // Expected results, oldest first
  note_s nt;
  event look; // Raised when a result is due
  logic [7:0] got, lfsr, want;
  int n_mismatch = 0;
  int num_checks = 0;
  int meas; // Bench measurement
  // ----------------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  far_side_model i_far (.mclk(mclk), .run(run), .fail_req(fail_req), .switch_clk(switch_clk),
    .power_fail_n(power_fail_n));
  buck_mode_ctrl i_dut (.mclk(mclk), .reset(reset), .cfg(cfg), .seq_enable(seq_enable),
    .global_lowpower_bit(global_lowpower_bit), .gp_pin0(gp_pin0), .gp_pin0_lp_en(gp_pin0_lp_en),
    .hw_enable_pin(hw_enable_pin), .gp_pin5(gp_pin5), .gp_pin6(gp_pin6),
    .alt_function_en5(alt_function_en5), .alt_function_en6(alt_function_en6),
    .pin_polarity_sel(pin_polarity_sel), .softstart_rate_fuse(softstart_rate_fuse),
    .power_fail_n(power_fail_n), .power_good_irq_mask(power_good_irq_mask),
    .power_good_irq_clear(power_good_irq_clear), .switch_clk(switch_clk), .stat(stat),
    .power_good_irq(power_good_irq), .power_good_flag(power_good_flag), .stage_start(stage_start));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Kinds: 0 enable/lp/sense, 1 ref, 2 irq/flags, 3 measure, 4 pg mask
  function automatic logic [7:0] obs(input int k, input int i);
    case (k)
      0: obs = {5'h00, stat[i].enabled, stat[i].lowpower, stat[i].remote_sense};
      1: obs = stat[i].ref_code;
      2: obs = {3'h0, power_good_irq, power_good_flag};
      3: obs = meas[7:0];
      default: obs = {7'h00, stat[i].pg_masked};
    endcase
  endfunction : obs
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    next_rand = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_rand
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  task automatic expect_val(input int k, input int i, input logic [7:0] w);
    q.push_back('{k, i, w});
    ->look;
  endtask : expect_val
  task automatic print_verdict();
    #1;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic timeout();
    n_mismatch++;
    $display("unexpected at %0t: wait limit got %h want %h", $time, 8'h01, 8'h00);
    print_verdict();
  endtask : timeout
  // Waits until the ramp of regulator i is finished
  task automatic wait_idle(input int i);
    int n;
    n = 0;
    tick(2);
    while (stat[i].pg_masked !== 1'b0 && n < 9000) begin
      tick(1);
      n++;
    end
    if (n >= 9000) timeout();
  endtask : wait_idle
  // Measures cycles between two successive reference steps
  task automatic step_time(input int i);
    logic [7:0] prev;
    int n;
    prev = stat[i].ref_code;
    n = 0;
    while (stat[i].ref_code === prev && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) timeout();
    prev = stat[i].ref_code;
    meas = 0;
    while (stat[i].ref_code === prev && meas < 200) begin
      tick(1);
      meas++;
    end
  endtask : step_time
  task automatic wait_sw(input logic lvl);
    for (int n = 0; n < 100 && switch_clk !== lvl; n++) tick(1);
    if (switch_clk !== lvl) timeout();
    seen = 5'h00;
    // Start pulses stand one cycle, so sampling every cycle catches each
    repeat (6) begin
      tick(1);
      seen |= stage_start;
    end
  endtask : wait_sw
  // ----------------------------------------------------------------------
  // Monitor: compares each due result against the oldest note
  // ----------------------------------------------------------------------
  initial begin
    forever begin
      @(look);
      while (q.size() > 0) begin
        nt = q.pop_front();
        got = obs(nt.k, nt.i);
        num_checks++;
        if (got !== nt.want) begin
          n_mismatch++;
          $display("unexpected at %0t: got %h want %h", $time, got, nt.want);
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {reset, cfg, seq_enable, global_lowpower_bit, gp_pin0, gp_pin0_lp_en, hw_enable_pin} = '0;
    {gp_pin5, gp_pin6, alt_function_en5, alt_function_en6, pin_polarity_sel} = 6'h00;
    {softstart_rate_fuse, power_good_irq_mask, power_good_irq_clear, run, fail_req} = 8'h00;
    reset = 1'b1;
    seen = 5'h00;
    lfsr = 8'h4E;
    tick(3);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) expect_val(1, i, 8'h00);
    // Mode codes against the global low-power signal on buck_c
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 2; g++) begin
        cfg[2].power_mode = m[1:0];
        global_lowpower_bit = g[0];
        tick(2);
        expect_val(0, 2, {5'h00, 1'(m != 0), 1'((m == 2) || (m == 1 && g == 1)), 1'b0});
      end
    end
    cfg[2].power_mode = 2'h1;
    global_lowpower_bit = 1'b0;
    gp_pin0 = 1'b1;
    gp_pin0_lp_en = 1'b1;
    tick(5);
    expect_val(0, 2, 8'h06);
    gp_pin0_lp_en = 1'b0;
    tick(2);
    expect_val(0, 2, 8'h04);
    // Sequencer owns enable, mode still picks power
    cfg[3].power_mode = 2'h3;
    cfg[3].seq_sel = 1'b1;
    tick(2);
    expect_val(0, 3, 8'h00);
    seq_enable = 4'h8;
    tick(2);
    expect_val(0, 3, 8'h04);
    cfg[3].power_mode = 2'h2;
    tick(2);
    expect_val(0, 3, 8'h06);
    hw_enable_pin = 1'b1;
    tick(5);
    expect_val(0, 0, 8'h04);
    $display("test modes finished");
    // Soft-start rate, masking and clamping on buck_a and buck_b
    hw_enable_pin = 1'b0;
    tick(5);
    expect_val(0, 0, 8'h00);
    softstart_rate_fuse = 1'b1;
    cfg[0].main_target_code = 8'hFF;
    cfg[0].power_mode = 2'h3;
    step_time(0);
    expect_val(3, 0, 8'h19);
    expect_val(4, 0, 8'h01);
    wait_idle(0);
    expect_val(1, 0, buck_ctrl_pkg::MAX_CODE_A);
    softstart_rate_fuse = 1'b0;
    cfg[1].main_target_code = 8'hFF;
    cfg[1].power_mode = 2'h3;
    step_time(1);
    expect_val(3, 1, 8'h32);
    wait_idle(1);
    expect_val(1, 1, buck_ctrl_pkg::MAX_CODE_B);
    // Restart into a held reference on buck_c
    softstart_rate_fuse = 1'b1;
    cfg[2].main_target_code = 8'h10;
    cfg[2].power_mode = 2'h3;
    wait_idle(2);
    cfg[2].power_mode = 2'h0;
    tick(2);
    cfg[2].main_target_code = 8'h20;
    cfg[2].power_mode = 2'h3;
    tick(2);
    expect_val(1, 2, 8'h10);
    wait_idle(2);
    $display("test soft-start finished");
    // Slewed scaling, settings changed only while idle
    cfg[2].slew_rate_sel = 2'h1;
    cfg[2].main_target_code = 8'h28;
    step_time(2);
    expect_val(3, 2, 8'h18);
    expect_val(4, 2, 8'h01);
    wait_idle(2);
    cfg[2].fall_slew_adjust_n = 1'b1;
    cfg[2].main_target_code = 8'h20;
    step_time(2);
    expect_val(3, 2, 8'h30);
    wait_idle(2);
    cfg[2].slew_rate_sel = 2'h0;
    cfg[2].fall_slew_adjust_n = 1'b0;
    for (int r = 0; r < 3; r++) begin
      lfsr = next_rand(lfsr);
      want = (lfsr > buck_ctrl_pkg::MAX_CODE_CD) ? buck_ctrl_pkg::MAX_CODE_CD : lfsr;
      cfg[2].main_target_code = lfsr;
      wait_idle(2);
      expect_val(1, 2, want);
    end
    // Pin-selected alternate target on buck_a
    cfg[0].alt_target_code = 8'h20;
    gp_pin5 = 1'b1;
    tick(6);
    expect_val(1, 0, buck_ctrl_pkg::MAX_CODE_A);
    alt_function_en5 = 1'b1;
    tick(6);
    wait_idle(0);
    expect_val(1, 0, 8'h20);
    pin_polarity_sel = 2'h1;
    tick(6);
    wait_idle(0);
    expect_val(1, 0, buck_ctrl_pkg::MAX_CODE_A);
    $display("test scaling finished");
    // Remote sense on buck_b across power modes
    cfg[1].remote_sense_en = 1'b1;
    tick(2);
    expect_val(0, 1, 8'h05);
    cfg[1].power_mode = 2'h2;
    tick(2);
    expect_val(0, 1, 8'h06);
    cfg[1].power_mode = 2'h3;
    tick(2);
    expect_val(0, 1, 8'h05);
    cfg[1].remote_sense_en = 1'b0;
    tick(2);
    expect_val(0, 1, 8'h04);
    // Power-fail interrupt on buck_d: plain, masked, during a ramp
    wait_idle(3);
    for (int mk = 0; mk < 2; mk++) begin
      power_good_irq_mask = mk[0];
      fail_req = 4'h8;
      tick(6);
      expect_val(2, 3, mk ? 8'h08 : 8'h18);
      power_good_irq_clear = 1'b1;
      fail_req = 4'h0;
      tick(1);
      power_good_irq_clear = 1'b0;
      tick(2);
      expect_val(2, 3, 8'h00);
    end
    power_good_irq_mask = 1'b0;
    cfg[3].main_target_code = 8'h30;
    tick(2);
    fail_req = 4'h8;
    tick(6);
    expect_val(2, 3, 8'h00);
    wait_idle(3);
    fail_req = 4'h0;
    $display("test interrupt finished");
    // Interleaved stage starts
    run = 1'b1;
    wait_sw(1'b1);
    meas = seen;
    expect_val(3, 0, 8'h03);
    wait_sw(1'b0);
    meas = seen;
    expect_val(3, 0, 8'h1C);
    $display("test stages finished");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
